// >>> rtl/itfcu_map.vh
`ifndef ITFCU_MAP_VH
`define ITFCU_MAP_VH

// operation codes
`define ITFCU_OP_CONV 8'h14
`define ITFCU_OP_CONV_RZ 8'h75
`define ITFCU_OP_FLAGS 8'h82
`define ITFCU_OP_FLAGS_RZ 8'h76

// issue slots accepting the unit
`define ITFCU_SLOT_A 3'h1
`define ITFCU_SLOT_B 3'h4

// exception flag positions, shared by status word and flag vector
`define ITFCU_F_DBZ 0
`define ITFCU_F_INX 1
`define ITFCU_F_UNF 2
`define ITFCU_F_OVF 3
`define ITFCU_F_INV 4
`define ITFCU_F_IFZ 5
`define ITFCU_F_OFZ 6
`define ITFCU_FLAG_W 7

// rounding modes
`define ITFCU_RM_NEAREST 2'h0
`define ITFCU_RM_POS 2'h1
`define ITFCU_RM_NEG 2'h2
`define ITFCU_RM_ZERO 2'h3

// status word layout
`define ITFCU_SW_FLAGS_HI 6
`define ITFCU_SW_MODE_LO 8
`define ITFCU_SW_MODE_HI 9

// register byte offsets
`define ITFCU_OFF_STATUS 12'h000
`define ITFCU_OFF_COUNT 12'h004

// reset values
`define ITFCU_RST_FLAGS 7'h00
`define ITFCU_RST_MODE 2'h0

// float format
`define ITFCU_EXP_TOP 8'h9e
`define ITFCU_NORM_LSB 8
`define ITFCU_GUARD_BIT 7
`endif

// >>> rtl/itfcu_convert.v
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "itfcu_map.vh"

module itfcu_convert #(
   parameter DEST_W = 7
) (
   input wire clk, // 20 MHz processor clock
   input wire rst, // synchronous, active high
   input wire issueValid, // one-cycle issue pulse
   input wire [7:0] issueOpcode, // operation code
   input wire [2:0] issueSlot, // issue slot number
   input wire [31:0] sourceRegister, // signed integer operand
   input wire guardLsb, // guard register lsb, 1 when unguarded
   input wire [DEST_W-1:0] issueDest, // destination register index
   input wire [6:0] otherFlagSet, // flag sets from other fp units this cycle
   output reg wbValid_q, // destination write strobe
   output reg [DEST_W-1:0] wbDest_q, // destination index
   output reg [31:0] wbData_q, // destination data
   output reg [6:0] swFlags_q, // sticky exception flags
   output reg [1:0] swMode_q, // rounding mode
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire [11:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr // apb error
);

   function [5:0] leadZeros;
      input [31:0] v;
      integer i;
      reg found;
      begin
         leadZeros = 6'h20;
         found = 1'b0;
         for (i = 31; i >= 0; i = i - 1) begin
            if (!found && v[i]) begin
               leadZeros = 6'h1f - i[5:0];
               found = 1'b1;
            end
         end
      end
   endfunction

   function isMapped;
      input [11:0] a;
      begin
         isMapped = (a == `ITFCU_OFF_STATUS) || (a == `ITFCU_OFF_COUNT);
      end
   endfunction

   // carry into the significand lsb for the rounding mode held with the op
   function roundIncrement;
      input [1:0] mode;
      input sign;
      input lsb;
      input guard;
      input sticky;
      begin
         case (mode)
            `ITFCU_RM_NEAREST: roundIncrement = guard & (sticky | lsb);
            `ITFCU_RM_POS: roundIncrement = ~sign & (guard | sticky);
            `ITFCU_RM_NEG: roundIncrement = sign & (guard | sticky);
            `ITFCU_RM_ZERO: roundIncrement = 1'b0;
            default: roundIncrement = 1'b0;
         endcase
      end
   endfunction

   // read data of the mapped words; unmapped reads give zero
   function [31:0] readWord;
      input [11:0] a;
      input [6:0] flags;
      input [1:0] mode;
      input [31:0] count;
      begin
         case (a)
            `ITFCU_OFF_STATUS: readWord = {22'h00_0000, mode, 1'b0, flags};
            `ITFCU_OFF_COUNT: readWord = count;
            default: readWord = 32'h0000_0000;
         endcase
      end
   endfunction

   // stage A: operand capture
   reg aValid_q;
   reg aFlagsOp_q;
   reg aSign_q;
   reg [31:0] aMag_q;
   reg [1:0] aMode_q;
   reg [DEST_W-1:0] aDest_q;
   // stage B: normalised
   reg bValid_q;
   reg bFlagsOp_q;
   reg bSign_q;
   reg bZero_q;
   reg [31:0] bNorm_q;
   reg [7:0] bExp_q;
   reg [1:0] bMode_q;
   reg [DEST_W-1:0] bDest_q;
   reg [31:0] convCount_q;

   wire opConv = (issueOpcode == `ITFCU_OP_CONV);
   wire opConvRz = (issueOpcode == `ITFCU_OP_CONV_RZ);
   wire opFlags = (issueOpcode == `ITFCU_OP_FLAGS);
   wire opFlagsRz = (issueOpcode == `ITFCU_OP_FLAGS_RZ);
   wire opKnown = opConv | opConvRz | opFlags | opFlagsRz;
   wire slotOk = (issueSlot == `ITFCU_SLOT_A) || (issueSlot == `ITFCU_SLOT_B);
   // a false guard drops the op at issue; nothing is written later
   wire issueTake = issueValid & opKnown & slotOk & guardLsb;
   wire [31:0] negSrc = ~sourceRegister + 32'h0000_0001;
   wire srcSign = sourceRegister[31];

   // stage A next values
   reg aValid_d;
   reg aFlagsOp_d;
   reg aSign_d;
   reg [31:0] aMag_d;
   reg [1:0] aMode_d;
   reg [DEST_W-1:0] aDest_d;

   always @* begin
      aValid_d = issueTake;
      aFlagsOp_d = opFlags | opFlagsRz;
      aSign_d = srcSign;
      // -2^31 negates to itself, which is the right magnitude unsigned
      aMag_d = srcSign ? negSrc : sourceRegister;
      // mode frozen at issue, so a status write behind the op cannot reach it
      aMode_d = (opConvRz | opFlagsRz) ? `ITFCU_RM_ZERO : swMode_q;
      aDest_d = issueDest;
   end

   always @(posedge clk) begin
      if (rst) begin
         aValid_q <= 1'b0;
         aFlagsOp_q <= 1'b0;
         aSign_q <= 1'b0;
         aMag_q <= 32'h0000_0000;
         aMode_q <= `ITFCU_RM_NEAREST;
         aDest_q <= {DEST_W{1'b0}};
      end else begin
         aValid_q <= aValid_d;
         aFlagsOp_q <= aFlagsOp_d;
         aSign_q <= aSign_d;
         aMag_q <= aMag_d;
         aMode_q <= aMode_d;
         aDest_q <= aDest_d;
      end
   end

   wire [5:0] aLz = leadZeros(aMag_q);
   wire aZero = (aMag_q == 32'h0000_0000);

   // stage B next values: leading one moved up to bit 31
   reg bValid_d;
   reg bFlagsOp_d;
   reg bSign_d;
   reg bZero_d;
   reg [31:0] bNorm_d;
   reg [7:0] bExp_d;
   reg [1:0] bMode_d;
   reg [DEST_W-1:0] bDest_d;

   always @* begin
      bValid_d = aValid_q;
      bFlagsOp_d = aFlagsOp_q;
      bSign_d = aSign_q;
      bZero_d = aZero;
      bNorm_d = aMag_q << aLz;
      // exponent of a value with its top set bit in bit 31, less the shift
      bExp_d = `ITFCU_EXP_TOP - {2'b00, aLz};
      bMode_d = aMode_q;
      bDest_d = aDest_q;
   end

   always @(posedge clk) begin
      if (rst) begin
         bValid_q <= 1'b0;
         bFlagsOp_q <= 1'b0;
         bSign_q <= 1'b0;
         bZero_q <= 1'b0;
         bNorm_q <= 32'h0000_0000;
         bExp_q <= 8'h00;
         bMode_q <= `ITFCU_RM_NEAREST;
         bDest_q <= {DEST_W{1'b0}};
      end else begin
         bValid_q <= bValid_d;
         bFlagsOp_q <= bFlagsOp_d;
         bSign_q <= bSign_d;
         bZero_q <= bZero_d;
         bNorm_q <= bNorm_d;
         bExp_q <= bExp_d;
         bMode_q <= bMode_d;
         bDest_q <= bDest_d;
      end
   end

   // rounding of the 24-bit significand
   wire [23:0] mant = bNorm_q[31:`ITFCU_NORM_LSB];
   wire guardBit = bNorm_q[`ITFCU_GUARD_BIT];
   wire stickyBit = |bNorm_q[`ITFCU_GUARD_BIT-1:0];
   wire inexact = guardBit | stickyBit;
   wire roundUp = roundIncrement(bMode_q, bSign_q, mant[0], guardBit, stickyBit);
   wire [24:0] mantSum = {1'b0, mant} + {24'h00_0000, roundUp};
   wire [7:0] expRound = bExp_q + {7'h00, mantSum[24]};
   wire [22:0] fracRound = mantSum[24] ? 23'h00_0000 : mantSum[22:0];
   wire [31:0] floatOut = bZero_q ? 32'h0000_0000 : {bSign_q, expRound, fracRound};

   // only inexact can arise; the other six stay zero
   reg [6:0] convFlags;
   always @* begin
      convFlags = 7'h00;
      convFlags[`ITFCU_F_INX] = inexact & ~bZero_q;
   end
   wire [31:0] flagVector = {25'h000_0000, convFlags};

   wire convWrite = bValid_q & ~bFlagsOp_q;

   reg wbValid_d;
   reg [DEST_W-1:0] wbDest_d;
   reg [31:0] wbData_d;

   always @* begin
      wbValid_d = bValid_q;
      wbDest_d = bDest_q;
      wbData_d = bFlagsOp_q ? flagVector : floatOut;
   end

   always @(posedge clk) begin
      if (rst) begin
         wbValid_q <= 1'b0;
         wbDest_q <= {DEST_W{1'b0}};
         wbData_q <= 32'h0000_0000;
      end else begin
         wbValid_q <= wbValid_d;
         wbDest_q <= wbDest_d;
         wbData_q <= wbData_d;
      end
   end

   // apb: no wait states; pready is a flop set by the setup phase, high in the first access cycle
   wire apbSetup = psel & ~penable;
   wire apbDone = psel & penable & pready;
   wire swWrite = apbDone & pwrite & (paddr == `ITFCU_OFF_STATUS);

   // sets win over a same-cycle clear by software
   wire [6:0] flagBase = swWrite ? pwdata[`ITFCU_SW_FLAGS_HI:0] : swFlags_q;
   wire [6:0] convSet = convWrite ? convFlags : 7'h00;
   wire [6:0] swFlags_d = flagBase | convSet | otherFlagSet;
   reg [1:0] swMode_d;
   reg [31:0] convCount_d;

   always @* begin
      swMode_d = swMode_q;
      if (swWrite) begin
         swMode_d = pwdata[`ITFCU_SW_MODE_HI:`ITFCU_SW_MODE_LO];
      end
      // completed conversions only; dropped ops and flag ops are not counted
      convCount_d = convCount_q;
      if (convWrite) begin
         convCount_d = convCount_q + 32'h0000_0001;
      end
   end

   reg pready_d;
   reg pslverr_d;
   reg [31:0] prdata_d;

   always @* begin
      pready_d = apbSetup;
      pslverr_d = apbSetup & ~isMapped(paddr);
      // read data is held between reads; it only matters while pready is high
      prdata_d = prdata;
      if (apbSetup & ~pwrite) begin
         prdata_d = readWord(paddr, swFlags_q, swMode_q, convCount_q);
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         swFlags_q <= `ITFCU_RST_FLAGS;
         swMode_q <= `ITFCU_RST_MODE;
         convCount_q <= 32'h0000_0000;
      end else begin
         swFlags_q <= swFlags_d;
         swMode_q <= swMode_d;
         convCount_q <= convCount_d;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= pready_d;
         pslverr <= pslverr_d;
         prdata <= prdata_d;
      end
   end

endmodule // itfcu_convert

// >>> tb/itfcu_rf.sv
`timescale 1ns/1ps
module itfcu_rf #(parameter DEST_W = 7) (
   input wire clk, // clock
   input wire wbValid_q, // write strobe
   input wire [DEST_W-1:0] wbDest_q, // index
   input wire [31:0] wbData_q // data
);
   logic [31:0] mem [0:(1<<DEST_W)-1];
   initial foreach (mem[k]) mem[k] = 32'h0000_0000;
   always @(posedge clk) begin
      if (wbValid_q) mem[wbDest_q] <= wbData_q;
   end
endmodule // itfcu_rf

// >>> tb/itfcu_monitor.sv
`timescale 1ns/1ps
`include "itfcu_map.vh"
module itfcu_monitor #(parameter DEST_W = 7) (
   input wire clk, // clock
   input wire rst, // reset
   input wire issueValid, // issue
   input wire [7:0] issueOpcode, // op
   input wire [2:0] issueSlot, // slot
   input wire guardLsb, // guard
   input wire [DEST_W-1:0] issueDest, // dest
   input wire [6:0] otherFlagSet, // sets
   input wire wbValid_q, // strobe
   input wire [DEST_W-1:0] wbDest_q, // dest
   input wire [31:0] wbData_q, // data
   input wire [6:0] swFlags_q, // flags
   input wire psel, // apb
   input wire penable, // apb
   input wire pwrite, // apb
   input wire [11:0] paddr, // apb
   input wire pready, // apb
   input wire pslverr // apb
);
   wire isF = issueOpcode == `ITFCU_OP_FLAGS || issueOpcode == `ITFCU_OP_FLAGS_RZ;
   wire isC = issueOpcode == `ITFCU_OP_CONV || issueOpcode == `ITFCU_OP_CONV_RZ;
   wire slotOk = issueSlot == `ITFCU_SLOT_A || issueSlot == `ITFCU_SLOT_B;
   wire takeOk = issueValid && guardLsb && slotOk && (isF || isC);
   wire swWr = psel && penable && pwrite && paddr == `ITFCU_OFF_STATUS;
   wire badA = paddr != `ITFCU_OFF_STATUS && paddr != `ITFCU_OFF_COUNT;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   lat_three_a: assert property (takeOk |-> ##3 wbValid_q)
      else $error("writeback missing");
   no_spurious_a: assert property (wbValid_q |-> $past(takeOk, 3))
      else $error("writeback without issue");
   dest_kept_a: assert property (takeOk |-> ##3 wbDest_q == $past(issueDest, 3))
      else $error("wrong destination");
   vec_layout_a: assert property (takeOk && isF |-> ##3 (wbData_q & 32'hffff_fffd) == 0)
      else $error("flag vector bits");
   inx_only_a: assert property (!$past(swWr) && $past(otherFlagSet) == 0 |->
      ((swFlags_q & ~$past(swFlags_q)) & 7'h7d) == 0)
      else $error("non-inexact flag set");
   flags_sticky_a: assert property (!$past(swWr) |->
      (swFlags_q & $past(swFlags_q)) == $past(swFlags_q))
      else $error("flag cleared");
   or_merge_a: assert property (otherFlagSet != 0 |=>
      (swFlags_q & $past(otherFlagSet)) == $past(otherFlagSet))
      else $error("flag set lost");
   apb_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready");
   apb_unmapped_a: assert property (psel && !penable && badA |=> pslverr)
      else $error("no slave error");
endmodule // itfcu_monitor
bind itfcu_convert itfcu_monitor #(.DEST_W(DEST_W)) i_mon (.clk, .rst, .issueValid,
   .issueOpcode, .issueSlot, .guardLsb, .issueDest, .otherFlagSet, .wbValid_q, .wbDest_q,
   .wbData_q, .swFlags_q, .psel, .penable, .pwrite, .paddr, .pready, .pslverr);

// >>> tb/int_to_float_convert_unit_test.sv
`timescale 1ns/1ps
`include "itfcu_map.vh"
module int_to_float_convert_unit_test;
   logic clk = 0, rst = 1, issueValid = 0, guardLsb = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] issueOpcode = 0;
   logic [2:0] issueSlot = 1;
   logic [31:0] sourceRegister = 0, pwdata = 0, rd;
   logic [6:0] issueDest = 0, otherFlagSet = 0, flagsM = 0;
   logic [11:0] paddr = 0;
   logic err;
   wire wbValid_q, pready, pslverr;
   wire [6:0] wbDest_q, swFlags_q;
   wire [31:0] wbData_q, prdata;
   wire [1:0] swMode_q;
   integer num_errors = 0, tests_run = 0, seed = 42, cyc = 0, i, convs = 0;
   logic [31:0] tbl [7] = '{3, -1, -3, 32'h7fff_ffff, 32'h8000_0000, 32'h7fff_fff1, 0};
   logic [7:0] ops [4] = '{`ITFCU_OP_CONV, `ITFCU_OP_CONV_RZ, `ITFCU_OP_FLAGS, `ITFCU_OP_FLAGS_RZ};
   itfcu_convert i_dut (.clk, .rst, .issueValid, .issueOpcode, .issueSlot, .sourceRegister,
      .guardLsb, .issueDest, .otherFlagSet, .wbValid_q, .wbDest_q, .wbData_q, .swFlags_q,
      .swMode_q, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   itfcu_rf i_rf (.clk, .wbValid_q, .wbDest_q, .wbData_q);
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc > 20000) begin
         num_errors++;
         final_report();
      end
   end
   task final_report;
      if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   function automatic logic [32:0] fconv(input logic [31:0] s, input logic [1:0] m);
      longint mag, keep, rem, half;
      integer p, e;
      logic up;
      mag = $signed(s);
      if (s[31]) mag = -mag;
      if (mag == 0) return 0;
      p = 0;
      rem = 0;
      while ((mag >> (p + 1)) != 0) p++;
      e = 127 + p;
      keep = mag << 23 >> p;
      if (p > 23) begin
         keep = mag >> (p - 23);
         rem = mag - (keep << (p - 23));
         half = 64'd1 << (p - 24);
         up = m == 0 ? (rem > half || rem == half && keep[0]) : m == 1 ? rem != 0 && !s[31] :
            m == 2 ? rem != 0 && s[31] : 0;
         keep += up;
         if (keep >> 24) begin
            keep >>= 1;
            e++;
         end
      end
      return {rem != 0, s[31], e[7:0], keep[22:0]};
   endfunction
   task automatic op(input logic [7:0] o, input logic [2:0] sl, input logic g, logic [31:0] s,
      input logic [1:0] m);
      logic [32:0] r;
      logic [31:0] old, ex;
      logic [6:0] d;
      logic ok, cv;
      d = $random(seed);
      old = i_rf.mem[d];
      cv = o == ops[0] || o == ops[1];
      ok = g && (sl == 1 || sl == 4) && (cv || o == ops[2] || o == ops[3]);
      r = fconv(s, (o == ops[0] || o == ops[2]) ? m : `ITFCU_RM_ZERO);
      ex = cv ? r[31:0] : {30'h0, r[32], 1'b0};
      @(posedge clk);
      issueValid <= 1;
      issueOpcode <= o;
      issueSlot <= sl;
      guardLsb <= g;
      sourceRegister <= s;
      issueDest <= d;
      @(posedge clk);
      issueValid <= 0;
      repeat (2) @(posedge clk);
      #1;
      chk(wbValid_q, ok);
      if (ok) chk(wbData_q, ex);
      if (ok && cv) flagsM[1] |= r[32];
      if (ok && cv) convs++;
      chk(swFlags_q, flagsM);
      @(posedge clk);
      #1 chk(i_rf.mem[d], ok ? ex : old);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 0;
      apb(0, `ITFCU_OFF_STATUS, 0);
      chk(rd, 0);
      for (i = 0; i < 256; i++) begin
         flagsM = 0;
         apb(1, `ITFCU_OFF_STATUS, {22'h0, i[1:0], 8'h00});
         #1 chk(swMode_q, i[1:0]);
         // group 10 issues an unused opcode, which must be ignored
         op(i[7:4] == 10 ? 8'h15 : ops[i[3:2]], i[7:4] == 8 ? 3'h2 : (i[4] ? 3'h4 : 3'h1),
            i[7:4] != 9,
            i[7:4] < 7 ? tbl[i[6:4]] : $random(seed), i[1:0]);
      end
      apb(0, `ITFCU_OFF_COUNT, 0);
      chk(rd, convs);
      @(posedge clk) otherFlagSet <= 7'h55;
      @(posedge clk) otherFlagSet <= 0;
      flagsM |= 7'h55;
      #1 chk(swFlags_q, flagsM);
      op(ops[1], 1, 1, 32'h7fff_ffff, 0);
      apb(1, `ITFCU_OFF_STATUS, 0);
      apb(0, `ITFCU_OFF_STATUS, 0);
      chk(rd, 0);
      apb(0, 12'h008, 0);
      chk(rd, 0);
      chk(err, 1);
      final_report();
   end
endmodule // int_to_float_convert_unit_test
